/* pkg/sac_pkg.sv */
// Package for the stereo amplifier control register bank.
// Assumes a 10 MHz mclk and an open-drain two-wire serial bus outside.
package sac_pkg;
   localparam logic [6:0] TARGET_ADDR   = 7'h31;
   localparam int         WORD_BITS     = 16;
   localparam int         NUM_RW_REGS   = 6;
   localparam logic [6:0] ADDR_LGAIN    = 7'h00;
   localparam logic [6:0] ADDR_RGAIN    = 7'h01;
   localparam logic [6:0] ADDR_MODE     = 7'h02;
   localparam logic [6:0] ADDR_LVL_TIME = 7'h03;
   localparam logic [6:0] ADDR_LVL_SET  = 7'h04;
   localparam logic [6:0] ADDR_SHUTDOWN = 7'h05;
   localparam logic [6:0] ADDR_ERR      = 7'h06;
   localparam logic [6:0] ADDR_ERR_CLR  = 7'h07;
   localparam logic [6:0] ADDR_SOFT_RST = 7'h08;
   localparam logic [7:0] RST_LGAIN     = 8'h22;
   localparam logic [7:0] RST_RGAIN     = 8'h22;
   localparam logic [7:0] RST_MODE      = 8'h0C;
   localparam logic [7:0] RST_LVL_TIME  = 8'h2B;
   localparam logic [7:0] RST_LVL_SET   = 8'h4B;
   localparam logic [7:0] RST_SHUTDOWN  = 8'h03;
   localparam logic [7:0] RST_ERR       = 8'h00;
   localparam logic [7:0] MASK_MODE     = 8'h3F;
   localparam logic [7:0] MASK_LVL_TIME = 8'h3F;
   localparam logic [7:0] MASK_LVL_SET  = 8'hFF;
   localparam logic [7:0] MASK_SHUTDOWN = 8'h03;
   localparam logic [3:0] MASK_ERR      = 4'hF;
   localparam int         LINK_BIT      = 7;
   localparam int         MUTE_BIT      = 6;
   localparam int         LVL_EN_BIT    = 7;
   localparam logic [5:0] GAIN_MAX_CODE = 6'h2E;

   typedef enum logic [6:0] {
      SAC_IDLE  = 7'b0000001,
      SAC_ADDR  = 7'b0000010,
      SAC_AACK  = 7'b0000100,
      SAC_WBYTE = 7'b0001000,
      SAC_WACK  = 7'b0010000,
      SAC_RBYTE = 7'b0100000,
      SAC_RACK  = 7'b1000000
   } sac_state_t;

   typedef struct packed {
      logic [5:0] left_gain_step;
      logic [5:0] right_gain_step;
      logic       left_mute;
      logic       right_mute;
      logic [7:0] mode_ctrl;
      logic [7:0] lvl_timing;
      logic [7:0] lvl_settings;
      logic [1:0] shutdown;
   } sac_amp_ctrl_t;
endpackage

/* core/sac_regs.sv */
// Serial-bus target and control register bank of a stereo amplifier.
// Assumes scl/sda pins from outside the mclk domain, open-drain sda.
// Function
// RULE1: Gain code steps 0.5 dB from 1 dB; codes 46 and up saturate.
// RULE2: With level control on, left gain code drives both channels.
// RULE3: With level control enabled, gain code writes are ignored.
// RULE4: Left link bit set makes a left gain write load both gains.
// RULE5: Right link bit set makes a right gain write load both gains.
// RULE6: Left mute bit set mutes the left channel input.
// RULE7: Right mute bit set mutes the right channel input.
// RULE8: Control word is 16 bits MSB first: 7 address, 9 data bits.
// RULE9: Target answers at address 0x31; address byte LSB picks read.
// RULE10: Fixed-zero bits read as zero and ignore writes.
`timescale 1ns/1ps
module sac_regs
   import sac_pkg::*;
(
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // Serial bus pins
   input  wire logic                   scl,
   input  wire logic                   sda,
   output logic                        sda_val,
   output logic                        sda_oe,
   // Fault events from the amplifier
   input  wire logic [3:0]             fault,
   // Amplifier controls
   output sac_pkg::sac_amp_ctrl_t      amp_ctrl
);
   import sac_pkg::*;

   function automatic logic [5:0] sat_gain(input logic [5:0] code);
      sat_gain = (code >= GAIN_MAX_CODE) ? GAIN_MAX_CODE : code;
   endfunction

   logic [1:0]    scl_sync_q, sda_sync_q, scl_d2, sda_d2;
   logic [3:0]    flt_a_q, flt_b_q;
   logic          scl_p_q, sda_p_q;
   sac_state_t    st_q, st_d;
   logic [2:0]    bitc_q, bitc_d;
   logic [7:0]    sh_q, sh_d, hi_q, hi_d;
   logic [6:0]    ptr_q, ptr_d;
   logic          idx_q, idx_d, oe_q, oe_d;
   logic [7:0]    regs_q [NUM_RW_REGS];
   logic [7:0]    regs_d [NUM_RW_REGS];
   logic [3:0]    err_q, err_d;
   sac_amp_ctrl_t out_q, out_d;
   logic          rise, fall, start_c, stop_c, wr_en, lvl_on;
   logic [7:0]    nb, wr_data, rd_data;
   logic [6:0]    wr_addr;

   // Pin synchronisers
   assign scl_d2 = {scl_sync_q[0], scl};
   assign sda_d2 = {sda_sync_q[0], sda};
   always_ff @(posedge mclk) begin
      scl_sync_q <= scl_d2;
      sda_sync_q <= sda_d2;
      flt_a_q    <= fault;
      flt_b_q    <= flt_a_q;
   end

   assign rise    = scl_sync_q[1] & ~scl_p_q;
   assign fall    = ~scl_sync_q[1] & scl_p_q;
   assign start_c = scl_sync_q[1] & scl_p_q & sda_p_q & ~sda_sync_q[1];
   assign stop_c  = scl_sync_q[1] & scl_p_q & ~sda_p_q & sda_sync_q[1];
   assign nb      = {sh_q[6:0], sda_sync_q[1]};
   assign lvl_on  = regs_q[4][LVL_EN_BIT];
   assign sda_val = 1'b0;
   assign sda_oe  = oe_q;
   assign amp_ctrl = out_q;

   // Read data by register pointer
   always_comb begin
      case (ptr_q)
         ADDR_LGAIN, ADDR_RGAIN, ADDR_MODE,
         ADDR_LVL_TIME, ADDR_LVL_SET, ADDR_SHUTDOWN:
            rd_data = regs_q[ptr_q[2:0]];
         ADDR_ERR: rd_data = {4'h0, err_q};
         default:  rd_data = 8'h00;
      endcase
   end

   // Bus protocol engine
   always_comb begin
      st_d    = st_q;
      bitc_d  = bitc_q;
      sh_d    = sh_q;
      hi_d    = hi_q;
      ptr_d   = ptr_q;
      idx_d   = idx_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      wr_addr = hi_q[7:1];
      wr_data = nb;
      if (start_c) begin
         st_d   = SAC_ADDR;
         bitc_d = 3'h0;
         oe_d   = 1'b0;
      end else if (stop_c) begin
         st_d = SAC_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            SAC_IDLE: st_d = SAC_IDLE;
            SAC_ADDR, SAC_WBYTE: if (rise) begin
               sh_d   = nb;
               bitc_d = bitc_q + 3'h1;
               if (bitc_q == 3'h7) begin
                  if (st_q == SAC_ADDR) begin
                     // RULE9 target address match
                     st_d  = (nb[7:1] == TARGET_ADDR) ? SAC_AACK : SAC_IDLE;
                     idx_d = 1'b0;
                  end else if (!idx_q) begin
                     hi_d  = nb;
                     ptr_d = nb[7:1];
                     idx_d = 1'b1;
                     st_d  = SAC_WACK;
                  end else begin
                     // RULE8 word completes write
                     wr_en = 1'b1;
                     idx_d = 1'b0;
                     st_d  = SAC_WACK;
                  end
               end
            end
            SAC_AACK, SAC_WACK: if (fall) begin
               if (!oe_q) begin
                  oe_d = 1'b1;
               end else if (st_q == SAC_AACK && sh_q[0]) begin
                  st_d   = SAC_RBYTE;
                  bitc_d = 3'h0;
                  sh_d   = {ptr_q, 1'b0};
                  oe_d   = ptr_q[6] ? 1'b0 : 1'b1;
               end else begin
                  st_d   = SAC_WBYTE;
                  bitc_d = 3'h0;
                  oe_d   = 1'b0;
               end
            end
            SAC_RBYTE: if (fall) begin
               bitc_d = bitc_q + 3'h1;
               sh_d   = {sh_q[6:0], 1'b0};
               oe_d   = (bitc_q == 3'h7) ? 1'b0 : ~sh_q[6];
               if (bitc_q == 3'h7)
                  st_d = SAC_RACK;
            end
            SAC_RACK: if (rise) begin
               if (sda_sync_q[1])
                  st_d = SAC_IDLE;
               else
                  idx_d = ~idx_q;
            end else if (fall) begin
               st_d   = SAC_RBYTE;
               bitc_d = 3'h0;
               sh_d   = idx_q ? rd_data : {ptr_q, 1'b0};
               oe_d   = idx_q ? ~rd_data[7] : ~ptr_q[6];
            end
            default: st_d = SAC_IDLE;
         endcase
      end
   end

   // Register bank update
   always_comb begin
      regs_d = regs_q;
      // Sticky faults, a new event beats a clear
      err_d  = err_q | flt_b_q;
      if (wr_en) begin
         case (wr_addr)
            ADDR_LGAIN: begin
               // RULE10 bit 8 of the word is dropped
               regs_d[0][7:6] = wr_data[7:6];
               // RULE3 gain locked under level control
               if (!lvl_on) begin
                  regs_d[0][5:0] = wr_data[5:0];
                  // RULE4 left link loads both
                  if (wr_data[LINK_BIT])
                     regs_d[1][5:0] = wr_data[5:0];
               end
            end
            ADDR_RGAIN: begin
               regs_d[1][7:6] = wr_data[7:6];
               if (!lvl_on) begin
                  regs_d[1][5:0] = wr_data[5:0];
                  // RULE5 right link loads both
                  if (wr_data[LINK_BIT])
                     regs_d[0][5:0] = wr_data[5:0];
               end
            end
            // RULE10 fixed zero bits masked
            ADDR_MODE:     regs_d[2] = wr_data & MASK_MODE;
            ADDR_LVL_TIME: regs_d[3] = wr_data & MASK_LVL_TIME;
            ADDR_LVL_SET:  regs_d[4] = wr_data & MASK_LVL_SET;
            ADDR_SHUTDOWN: regs_d[5] = wr_data & MASK_SHUTDOWN;
            ADDR_ERR_CLR:  err_d = flt_b_q & MASK_ERR;
            ADDR_SOFT_RST: begin
               regs_d = '{RST_LGAIN, RST_RGAIN, RST_MODE,
                          RST_LVL_TIME, RST_LVL_SET, RST_SHUTDOWN};
               err_d  = RST_ERR[3:0];
            end
            default: regs_d = regs_q;
         endcase
      end
      // RULE1 saturated gain step
      out_d.left_gain_step  = sat_gain(regs_q[0][5:0]);
      // RULE2 left code shared under level control
      out_d.right_gain_step = lvl_on ? sat_gain(regs_q[0][5:0])
                                     : sat_gain(regs_q[1][5:0]);
      // RULE6 left mute
      out_d.left_mute       = regs_q[0][MUTE_BIT];
      // RULE7 right mute
      out_d.right_mute      = regs_q[1][MUTE_BIT];
      out_d.mode_ctrl       = regs_q[2];
      out_d.lvl_timing      = regs_q[3];
      out_d.lvl_settings    = regs_q[4];
      out_d.shutdown        = regs_q[5][1:0];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         st_q    <= SAC_IDLE;
         bitc_q  <= 3'h0;
         sh_q    <= 8'h00;
         hi_q    <= 8'h00;
         ptr_q   <= 7'h00;
         idx_q   <= 1'b0;
         oe_q    <= 1'b0;
         regs_q  <= '{RST_LGAIN, RST_RGAIN, RST_MODE,
                      RST_LVL_TIME, RST_LVL_SET, RST_SHUTDOWN};
         err_q   <= RST_ERR[3:0];
         out_q   <= '0;
      end else begin
         scl_p_q <= scl_sync_q[1];
         sda_p_q <= sda_sync_q[1];
         st_q    <= st_d;
         bitc_q  <= bitc_d;
         sh_q    <= sh_d;
         hi_q    <= hi_d;
         ptr_q   <= ptr_d;
         idx_q   <= idx_d;
         oe_q    <= oe_d;
         regs_q  <= regs_d;
         err_q   <= err_d;
         out_q   <= out_d;
      end
   end

   a_gain_sat: assert property (@(posedge mclk) disable iff (rst) // RULE1
      regs_q[0][5:0] >= GAIN_MAX_CODE |=> out_q.left_gain_step == 6'h2E)
      else $error("gain code did not saturate");
   a_alc_share: assert property (@(posedge mclk) disable iff (rst) // RULE2
      lvl_on |=> out_q.right_gain_step == out_q.left_gain_step)
      else $error("right gain not following left under level control");
   a_gain_lock: assert property (@(posedge mclk) disable iff (rst) // RULE3
      wr_en && lvl_on && wr_addr != ADDR_SOFT_RST
      |=> $stable(regs_q[0][5:0]) && $stable(regs_q[1][5:0]))
      else $error("gain changed while locked");
   a_left_link: assert property (@(posedge mclk) disable iff (rst) // RULE4
      wr_en && wr_addr == ADDR_LGAIN && !lvl_on && wr_data[7]
      |=> regs_q[1][5:0] == $past(wr_data[5:0]))
      else $error("left link did not load right gain");
   a_right_link: assert property (@(posedge mclk) disable iff (rst) // RULE5
      wr_en && wr_addr == ADDR_RGAIN && !lvl_on && wr_data[7]
      |=> regs_q[0][5:0] == $past(wr_data[5:0]))
      else $error("right link did not load left gain");
   a_left_mute: assert property (@(posedge mclk) disable iff (rst) // RULE6
      wr_en && wr_addr == ADDR_LGAIN
      |-> ##2 out_q.left_mute == $past(wr_data[MUTE_BIT], 2))
      else $error("left mute not applied");
   a_right_mute: assert property (@(posedge mclk) disable iff (rst) // RULE7
      regs_q[1][6] |=> out_q.right_mute)
      else $error("right mute not applied");
   a_word_end: assert property (@(posedge mclk) disable iff (rst) // RULE8
      wr_en |-> st_q == SAC_WBYTE && idx_q && bitc_q == 3'h7 && rise)
      else $error("write outside second data byte");
   a_addr_ack: assert property (@(posedge mclk) disable iff (rst) // RULE9
      st_q == SAC_AACK |-> sh_q[7:1] == TARGET_ADDR)
      else $error("acknowledged a foreign address");
   a_zero_bits: assert property (@(posedge mclk) disable iff (rst) // RULE10
      regs_q[5][7:2] == 6'h00 && regs_q[2][7:6] == 2'h0)
      else $error("fixed zero bit set");
endmodule

/* testbench/sac_host_model.sv */
// Host model: two-wire bus controller writing control words.
// Assumes the bench resolves open-drain sda with a pull-up.
`timescale 1ns/1ps
module sac_host_model (
   // Clock
   input  wire logic       mclk,
   // Bus pins
   input  wire logic       sda,
   output logic            scl,
   output logic            sda_pull,
   // Results
   output logic            res_valid,
   output logic [7:0]      res
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      res_valid = 1'b0;
      res = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic put(input logic [7:0] v);
      res <= v;
      res_valid <= 1'b1;
      tick(1);
      res_valid <= 1'b0;
   endtask
   task automatic start();
      sda_pull <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_pull <= 1'b1;
      tick(8);
      scl <= 1'b0;
      tick(4);
   endtask
   task automatic stop();
      sda_pull <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_pull <= 1'b0;
      tick(8);
   endtask
   task automatic get(input logic pull, output logic b);
      sda_pull <= pull;
      tick(4);
      scl <= 1'b1;
      tick(4);
      b = sda;
      tick(4);
      scl <= 1'b0;
      tick(4);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--) get(~b[i], x);
      get(1'b0, x);
      ack = ~x;
   endtask
   task automatic recv(output logic [7:0] b, input logic more);
      logic x;
      for (int i = 7; i >= 0; i--) get(1'b0, b[i]);
      get(more, x);
   endtask
   // address byte, then 7-bit addr and 9 data bits
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      logic k;
      start();
      send(8'h62, k);
      send({a, d[8]}, k);
      send(d[7:0], k);
      stop();
   endtask
   task automatic probe(input logic [6:0] a);
      logic k;
      start();
      send({a, 1'b0}, k);
      stop();
      put({7'h00, k});
   endtask
   // read address byte has its low bit set
   task automatic rd(input logic [6:0] a);
      logic [7:0] b;
      logic       k;
      start();
      send(8'h62, k);
      send({a, 1'b0}, k);
      stop();
      start();
      send(8'h63, k);
      recv(b, 1'b1);
      put(b);
      recv(b, 1'b0);
      put(b);
      stop();
   endtask
endmodule

/* testbench/stereo_amp_control_registers_tb_top.sv */
// Bench for the amplifier control register bank.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps
module stereo_amp_control_registers_tb_top;
   import sac_pkg::*;
   localparam logic [7:0] RV [0:8] = '{RST_LGAIN, RST_RGAIN, RST_MODE,
      RST_LVL_TIME, RST_LVL_SET, RST_SHUTDOWN, RST_ERR, 8'h00, 8'h00};
   logic          mclk;
   logic          rst;
   logic          scl;
   logic          pull;
   logic          sda_val;
   logic          sda_oe;
   logic [3:0]    fault;
   logic          amp_req;
   logic [1:0]    cfg_req;
   logic          res_valid;
   logic [7:0]    res;
   logic [5:0]    code;
   sac_amp_ctrl_t amp_ctrl;
   logic [15:0]   notes[$];
   string         names[$];
   int            bad_count;
   int            cmp_count;
   wire           sda = ~pull & (sda_oe ? sda_val : 1'b1);
   sac_regs sac_regs_inst (.mclk(mclk), .rst(rst), .scl(scl), .sda(sda),
      .sda_val(sda_val), .sda_oe(sda_oe), .fault(fault), .amp_ctrl(amp_ctrl));
   sac_host_model sac_host_model_inst (.mclk(mclk), .sda(sda), .scl(scl),
      .sda_pull(pull), .res_valid(res_valid), .res(res));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic note(input string n, input logic [15:0] v);
      names.push_back(n);
      notes.push_back(v);
   endtask
   task automatic w(input logic [6:0] a, input logic [7:0] d);
      sac_host_model_inst.wr(a, {1'b0, d});
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] v);
      note("pointer", {8'h00, a, 1'b0});
      note("read data", {8'h00, v});
      sac_host_model_inst.rd(a);
   endtask
   task automatic pr(input logic [6:0] a, input logic k);
      note("ack", {15'h0000, k});
      sac_host_model_inst.probe(a);
   endtask
   task automatic amp(input logic [5:0] l, input logic [5:0] r,
                      input logic [1:0] m);
      note("amp", {2'b00, l, r, m});
      amp_req <= 1'b1;
      @(posedge mclk);
      amp_req <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic cfg(input logic [7:0] m, input logic [7:0] s,
                      input logic [7:0] t, input logic [1:0] d);
      note("mode settings", {m, s});
      note("timing shutdown", {t, 6'h00, d});
      cfg_req <= 2'b01;
      @(posedge mclk);
      cfg_req <= 2'b10;
      @(posedge mclk);
      cfg_req <= 2'b00;
      @(posedge mclk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      logic [15:0] got;
      if (res_valid === 1'b1 || amp_req === 1'b1 || |cfg_req === 1'b1) begin
         if (amp_req === 1'b1)
            got = {2'b00, amp_ctrl.left_gain_step,
               amp_ctrl.right_gain_step, amp_ctrl.left_mute,
               amp_ctrl.right_mute};
         else if (cfg_req[0] === 1'b1)
            got = {amp_ctrl.mode_ctrl, amp_ctrl.lvl_settings};
         else if (cfg_req[1] === 1'b1)
            got = {amp_ctrl.lvl_timing, 6'h00, amp_ctrl.shutdown};
         else
            got = {8'h00, res};
         cmp_count++;
         if (notes.size() == 0) begin
            bad_count++;
            $display("wrong value result expected none seen %h", got);
         end else begin
            if (notes[0] !== got) begin
               bad_count++;
               $display("wrong value %s expected %h seen %h", names[0],
                  notes[0], got);
            end
            void'(notes.pop_front());
            void'(names.pop_front());
         end
      end
   end
   initial begin
      repeat (100000) @(posedge mclk);
      bad_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      fault = 4'h0;
      amp_req = 1'b0;
      cfg_req = 2'b00;
      bad_count = 0;
      cmp_count = 0;
      void'($urandom(32'hF672));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      amp(6'd34, 6'd34, 2'b00);
      for (int i = 0; i < 9; i++) rd(i[6:0], RV[i]);
      cfg(RST_MODE, RST_LVL_SET, RST_LVL_TIME, RST_SHUTDOWN[1:0]);
      w(ADDR_MODE, 8'hFF);
      rd(ADDR_MODE, 8'hFF & MASK_MODE);
      w(ADDR_LVL_TIME, 8'hFF);
      w(ADDR_SHUTDOWN, 8'hFE);
      rd(ADDR_SHUTDOWN, 8'hFE & MASK_SHUTDOWN);
      cfg(8'hFF & MASK_MODE, RST_LVL_SET, 8'hFF & MASK_LVL_TIME, 2'b10);
      $display("test reset done");
      w(ADDR_LGAIN, 8'h45);
      rd(ADDR_LGAIN, 8'h45);
      w(ADDR_RGAIN, 8'h47);
      amp(6'd5, 6'd7, 2'b11);
      w(ADDR_LVL_SET, 8'h0B);
      w(ADDR_RGAIN, 8'h14);
      w(ADDR_LGAIN, 8'h0A);
      amp(6'd10, 6'd20, 2'b00);
      w(ADDR_LVL_SET, 8'h8B);
      amp(6'd10, 6'd10, 2'b00);
      w(ADDR_LGAIN, 8'hBF);
      w(ADDR_RGAIN, 8'h3F);
      rd(ADDR_RGAIN, 8'h14);
      rd(ADDR_LGAIN, 8'h8A);
      amp(6'd10, 6'd10, 2'b00);
      w(ADDR_LVL_SET, 8'h0B);
      $display("test lock done");
      w(ADDR_LGAIN, 8'hBF);
      amp(6'd46, 6'd46, 2'b00);
      w(ADDR_RGAIN, 8'h80);
      rd(ADDR_LGAIN, 8'h80);
      w(ADDR_RGAIN, 8'h05);
      amp(6'd0, 6'd5, 2'b00);
      for (int i = 0; i < 6; i++) begin
         code = (i < 3) ? 6'(45 + i) : 6'($urandom_range(63, 0));
         w(ADDR_LGAIN, {2'b00, code});
         amp((code > 6'd46) ? 6'd46 : code, 6'd5, 2'b00);
      end
      $display("test link and gain done");
      pr(7'h30, 1'b0);
      pr(TARGET_ADDR, 1'b1);
      w(7'h09, 8'hFF);
      fault <= 4'h5;
      repeat (4) @(posedge mclk);
      fault <= 4'h0;
      w(ADDR_ERR, 8'hFF);
      rd(ADDR_ERR, 8'h05);
      w(ADDR_ERR_CLR, 8'h00);
      rd(ADDR_ERR, 8'h00);
      w(ADDR_SOFT_RST, 8'h00);
      rd(ADDR_LVL_SET, RST_LVL_SET);
      cfg(RST_MODE, RST_LVL_SET, RST_LVL_TIME, RST_SHUTDOWN[1:0]);
      amp(6'd34, 6'd34, 2'b00);
      $display("test faults done");
      for (int i = 0; i < 100 && notes.size() > 0; i++) @(posedge mclk);
      if (notes.size() > 0) bad_count++;
      complete_run();
   end
endmodule
